// ---- core/pbv_params.svh ----
`ifndef PBV_PARAMS_SVH
`define PBV_PARAMS_SVH

// register byte offsets
`define PBV_OFS_CTRL 8'h00
`define PBV_OFS_RISE 8'h04
`define PBV_OFS_FALL 8'h08
`define PBV_OFS_FACTOR 8'h0C
`define PBV_OFS_STEP 8'h10
`define PBV_OFS_STATUS 8'h14

// control field positions
`define PBV_CTRL_FUNC_LSB 0
`define PBV_CTRL_EDGE_LSB 4
`define PBV_CTRL_ADJ_BIT 8
`define PBV_CTRL_TB_LSB 12

// reset values and limits
`define PBV_RST_RISE 8'h64
`define PBV_RST_FALL 8'h00
`define PBV_RST_FACTOR 7'h03
`define PBV_RST_STEP 4'hA
`define PBV_RST_TB 2'h2
`define PBV_FACTOR_MIN 7'h03
`define PBV_STEP_MIN 4'h1
`define PBV_STEP_MAX 4'hA

// time bases and press limit in ms
`define PBV_TB0_MS 10'h082
`define PBV_TB1_MS 10'h104
`define PBV_TB2_MS 10'h208
`define PBV_TB3_MS 10'h3E8
`define PBV_PRESS_MAX_MS 13'h1388

// clock figures in ns
`define PBV_MS_NS 1000000
`define PBV_CLK_PERIOD_NS 8

`endif

// ---- core/pbv_pkg.sv ----
package pbv_pkg;

	typedef enum logic [2:0] {
		PBV_FN_DIM = 3'h0,
		PBV_FN_SCENE = 3'h1,
		PBV_FN_SCENE_MEM = 3'h2,
		PBV_FN_TEMP = 3'h3,
		PBV_FN_BRIGHT = 3'h4
	} pbv_func_t;

	typedef enum logic [1:0] {
		PBV_EDGE_RISE = 2'h0,
		PBV_EDGE_FALL = 2'h1,
		PBV_EDGE_BOTH = 2'h2
	} pbv_edge_t;

	typedef enum logic [1:0] {
		PBV_ST_IDLE = 2'b00,
		PBV_ST_HOLD = 2'b01,
		PBV_ST_DONE = 2'b10
	} pbv_state_t;

	// one outgoing telegram
	typedef struct packed {
		logic [2:0] func;
		logic [7:0] value;
	} pbv_tel_t;

endpackage

// ---- core/pbv_ms_tick.sv ----
`include "pbv_params.svh"

module pbv_ms_tick #(
	parameter int CYC_PER_MS = `PBV_MS_NS / `PBV_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// one-cycle pulse every millisecond
	output logic tick_out
);

	logic [19:0] cnt_q;

	// free running prescaler, shared by every ms timer of the channel
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= 20'h00000;
			tick_out <= 1'b0;
		end else if (cnt_q == 20'(CYC_PER_MS - 1)) begin
			cnt_q <= 20'h00000;
			tick_out <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 20'h00001;
			tick_out <= 1'b0;
		end
	end

endmodule

// ---- core/pbv_value_tx.sv ----
// Function
// - function selects telegram format and adjustment
// - edge setting: rising, falling or both
// - rising edge transmits rising value
// - falling edge transmits falling value
// - long press steps value cyclically, under 5 s
// - last transmitted value kept afterwards
// - adjustment enable, single-edge settings only
// - time base 130/260/520/1000 ms
// - interval is base times factor 3..127
// - step width 1..10, default 10
`include "pbv_params.svh"

module pbv_value_tx #(
	parameter int CYC_PER_MS = `PBV_MS_NS / `PBV_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// contact input
	input wire logic contact_in,
	// telegram transmitter
	input wire logic tx_ready_in,
	output logic tx_valid_out,
	output pbv_pkg::pbv_tel_t tx_tel_out
);

	logic ms_tick;
	logic contact_q;
	logic rise_evt, fall_evt, act_evt, rel_evt;
	logic wr_en, adj_ok, step_evt, scene;
	logic [2:0] func_q;
	logic [1:0] edge_q, tb_q;
	logic adj_en_q, dir_up_q, stepped_q;
	logic [7:0] rise_val_q, fall_val_q, cur_q, next_val;
	logic [6:0] factor_q;
	logic [3:0] step_q;
	logic [9:0] base_ms;
	logic [16:0] interval_ms, ms_cnt_q;
	logic [12:0] press_ms_q;
	logic [8:0] sum_up;
	pbv_pkg::pbv_state_t state_q;

	pbv_ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.tick_out(ms_tick)
	);

	// contact edges, input already synchronous
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			contact_q <= 1'b0;
		end else begin
			contact_q <= contact_in;
		end
	end

	assign rise_evt = contact_in & ~contact_q;
	assign fall_evt = ~contact_in & contact_q;
	// actuation start and release per edge setting
	assign act_evt = (edge_q == pbv_pkg::PBV_EDGE_RISE) ? rise_evt : (edge_q == pbv_pkg::PBV_EDGE_FALL) ? fall_evt :
		1'b0;
	assign rel_evt = (edge_q == pbv_pkg::PBV_EDGE_RISE) ? fall_evt : rise_evt;
	// scene numbers are 6 bits and never adjusted
	assign scene = (func_q == pbv_pkg::PBV_FN_SCENE) || (func_q == pbv_pkg::PBV_FN_SCENE_MEM);
	assign adj_ok = adj_en_q && (edge_q != pbv_pkg::PBV_EDGE_BOTH) && !scene;

	// bus write strobe: lands at the edge where the master sees ack, so an aborted cycle writes nothing
	assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;

	// time base lookup
	always_comb begin
		case (tb_q)
			2'h0: base_ms = `PBV_TB0_MS;
			2'h1: base_ms = `PBV_TB1_MS;
			2'h2: base_ms = `PBV_TB2_MS;
			default: base_ms = `PBV_TB3_MS;
		endcase
	end

	assign interval_ms = 17'(base_ms * factor_q);

	// configuration registers; illegal factor/step values clamp into range
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			func_q <= pbv_pkg::PBV_FN_DIM;
			edge_q <= pbv_pkg::PBV_EDGE_RISE;
			adj_en_q <= 1'b0;
			tb_q <= `PBV_RST_TB;
			rise_val_q <= `PBV_RST_RISE;
			fall_val_q <= `PBV_RST_FALL;
			factor_q <= `PBV_RST_FACTOR;
			step_q <= `PBV_RST_STEP;
		end else if (wr_en) begin
			case (wb_adr_in)
				`PBV_OFS_CTRL: begin
					if (wb_sel_in[0]) begin
						func_q <= wb_dat_in[`PBV_CTRL_FUNC_LSB +: 3];
						edge_q <= (wb_dat_in[`PBV_CTRL_EDGE_LSB +: 2] == 2'h3) ? pbv_pkg::PBV_EDGE_BOTH :
							wb_dat_in[`PBV_CTRL_EDGE_LSB +: 2];
					end
					if (wb_sel_in[1]) begin
						adj_en_q <= wb_dat_in[`PBV_CTRL_ADJ_BIT];
						tb_q <= wb_dat_in[`PBV_CTRL_TB_LSB +: 2];
					end
				end
				`PBV_OFS_RISE: if (wb_sel_in[0]) begin
					rise_val_q <= wb_dat_in[7:0];
				end
				`PBV_OFS_FALL: if (wb_sel_in[0]) begin
					fall_val_q <= wb_dat_in[7:0];
				end
				`PBV_OFS_FACTOR: if (wb_sel_in[0]) begin
					factor_q <= (wb_dat_in[6:0] < `PBV_FACTOR_MIN) ? `PBV_FACTOR_MIN : wb_dat_in[6:0];
				end
				`PBV_OFS_STEP: if (wb_sel_in[0]) begin
					step_q <= (wb_dat_in[7:0] < 8'(`PBV_STEP_MIN)) ? `PBV_STEP_MIN :
						(wb_dat_in[7:0] > 8'(`PBV_STEP_MAX)) ? `PBV_STEP_MAX : wb_dat_in[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// wishbone answer: ack one cycle after the strobe, unmapped reads as zero
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
			case (wb_adr_in)
				`PBV_OFS_CTRL: wb_dat_out <= {18'h00000, tb_q, 3'h0, adj_en_q, 2'h0, edge_q, 1'b0, func_q};
				`PBV_OFS_RISE: wb_dat_out <= {24'h000000, rise_val_q};
				`PBV_OFS_FALL: wb_dat_out <= {24'h000000, fall_val_q};
				`PBV_OFS_FACTOR: wb_dat_out <= {25'h0000000, factor_q};
				`PBV_OFS_STEP: wb_dat_out <= {28'h0000000, step_q};
				`PBV_OFS_STATUS: wb_dat_out <= {20'h00000, state_q, dir_up_q, contact_q, cur_q};
				default: wb_dat_out <= 32'h00000000;
			endcase
		end
	end

	// adjustment sequencer: interval waits, then a step, until release or 5 s
	assign step_evt = (state_q == pbv_pkg::PBV_ST_HOLD) && adj_ok && !rel_evt && ms_tick &&
		(ms_cnt_q + 17'h00001 >= interval_ms);
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= pbv_pkg::PBV_ST_IDLE;
			ms_cnt_q <= 17'h00000;
			press_ms_q <= 13'h0000;
			dir_up_q <= 1'b1;
			stepped_q <= 1'b0;
		end else begin
			case (state_q)
				pbv_pkg::PBV_ST_IDLE: begin
					ms_cnt_q <= 17'h00000;
					press_ms_q <= 13'h0000;
					stepped_q <= 1'b0;
					if (act_evt && adj_ok) begin
						state_q <= pbv_pkg::PBV_ST_HOLD;
					end
				end
				pbv_pkg::PBV_ST_HOLD: begin
					if (rel_evt || !adj_ok) begin
						state_q <= pbv_pkg::PBV_ST_IDLE;
						// next long press runs the other way
						if (stepped_q) begin
							dir_up_q <= ~dir_up_q;
						end
					end else if (ms_tick) begin
						press_ms_q <= press_ms_q + 13'h0001;
						ms_cnt_q <= step_evt ? 17'h00000 : ms_cnt_q + 17'h00001;
						if (step_evt) begin
							stepped_q <= 1'b1;
						end
						if (press_ms_q + 13'h0001 >= `PBV_PRESS_MAX_MS) begin
							state_q <= pbv_pkg::PBV_ST_DONE;
						end
					end
				end
				pbv_pkg::PBV_ST_DONE: begin
					if (rel_evt || !adj_ok) begin
						state_q <= pbv_pkg::PBV_ST_IDLE;
						if (stepped_q) begin
							dir_up_q <= ~dir_up_q;
						end
					end
				end
				default: state_q <= pbv_pkg::PBV_ST_IDLE;
			endcase
		end
	end

	// saturating step, never wraps
	assign sum_up = {1'b0, cur_q} + {5'h00, step_q};
	always_comb begin
		if (dir_up_q) begin
			next_val = sum_up[8] ? 8'hFF : sum_up[7:0];
		end else begin
			next_val = (cur_q < {4'h0, step_q}) ? 8'h00 : cur_q - {4'h0, step_q};
		end
	end

	// current value: loaded by software, moved by steps, kept between presses
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cur_q <= `PBV_RST_RISE;
		end else if (step_evt) begin
			cur_q <= next_val;
		end else if (wr_en && wb_sel_in[0] && ((wb_adr_in == `PBV_OFS_RISE && edge_q != pbv_pkg::PBV_EDGE_FALL) ||
			(wb_adr_in == `PBV_OFS_FALL && edge_q == pbv_pkg::PBV_EDGE_FALL))) begin
			cur_q <= wb_dat_in[7:0];
		end
	end

	// telegram out; a newer telegram overwrites one the transmitter has not taken
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_valid_out <= 1'b0;
			tx_tel_out <= '0;
		end else if (step_evt) begin
			tx_valid_out <= 1'b1;
			tx_tel_out <= {func_q, next_val};
		end else if (edge_q == pbv_pkg::PBV_EDGE_BOTH && (rise_evt || fall_evt)) begin
			tx_valid_out <= 1'b1;
			tx_tel_out.func <= func_q;
			tx_tel_out.value <= (rise_evt ? rise_val_q : fall_val_q) & (scene ? 8'h3F : 8'hFF);
		end else if (act_evt) begin
			tx_valid_out <= 1'b1;
			tx_tel_out.func <= func_q;
			// single edge settings send the retained value; scene functions send the rising or falling value masked to 6 bits
			tx_tel_out.value <= (scene ? ((edge_q == pbv_pkg::PBV_EDGE_RISE) ? rise_val_q : fall_val_q) & 8'h3F :
				cur_q);
		end else if (tx_ready_in) begin
			tx_valid_out <= 1'b0;
		end
	end

	a_ack_single: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		wb_ack_out |=> !wb_ack_out) else $error("ack held longer than one cycle");

	a_ack_after_req: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out) else $error("request not acked next cycle");

	a_both_rise_value: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(edge_q == pbv_pkg::PBV_EDGE_BOTH && rise_evt && !scene && !step_evt) |=>
		(tx_valid_out && tx_tel_out.value == $past(rise_val_q))) else $error("rising value not sent");

	a_both_fall_value: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(edge_q == pbv_pkg::PBV_EDGE_BOTH && fall_evt && !scene && !step_evt) |=>
		(tx_valid_out && tx_tel_out.value == $past(fall_val_q))) else $error("falling value not sent");

	a_adjust_gated: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(state_q == pbv_pkg::PBV_ST_HOLD && !adj_ok) |=> state_q == pbv_pkg::PBV_ST_IDLE)
		else $error("adjustment running while not allowed");

	a_step_amount: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(step_evt && dir_up_q && !sum_up[8]) |=> cur_q == $past(cur_q) + 8'($past(step_q)))
		else $error("step width not applied");

	a_step_saturate: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(step_evt && !dir_up_q && cur_q < {4'h0, step_q}) |=> (cur_q == 8'h00 && tx_tel_out.value == 8'h00))
		else $error("down step did not saturate");

	a_press_limit: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		state_q == pbv_pkg::PBV_ST_HOLD |-> press_ms_q < `PBV_PRESS_MAX_MS) else $error("adjusting past 5 s");

	a_value_retained: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(state_q == pbv_pkg::PBV_ST_IDLE && !wr_en) |=> cur_q == $past(cur_q)) else $error("value lost when idle");

	a_scene_masked: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(tx_valid_out && (tx_tel_out.func == pbv_pkg::PBV_FN_SCENE || tx_tel_out.func == pbv_pkg::PBV_FN_SCENE_MEM))
		|-> tx_tel_out.value[7:6] == 2'h0) else $error("scene number out of range");

	a_act_sends_value: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(act_evt && !step_evt && !scene) |=> (tx_valid_out && tx_tel_out.value == $past(cur_q)))
		else $error("actuation did not send the current value");

	a_rise_only_quiet: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(edge_q == pbv_pkg::PBV_EDGE_RISE && fall_evt && !step_evt && !tx_valid_out) |=> !tx_valid_out)
		else $error("release sent a telegram in rising-only mode");

	a_fall_only_quiet: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(edge_q == pbv_pkg::PBV_EDGE_FALL && rise_evt && !step_evt && !tx_valid_out) |=> !tx_valid_out)
		else $error("press sent a telegram in falling-only mode");

	a_step_down_amount: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(step_evt && !dir_up_q && cur_q >= {4'h0, step_q}) |=> cur_q == $past(cur_q) - 8'($past(step_q)))
		else $error("down step width not applied");

	a_step_saturate_up: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(step_evt && dir_up_q && sum_up[8]) |=> (cur_q == 8'hFF && tx_tel_out.value == 8'hFF))
		else $error("up step did not saturate");

endmodule

// ---- verification/pbv_contact_model.sv ----
// push-button contact at the binary input, no bounce modelled
module pbv_contact_model (
	// clock
	input wire logic clk_sys_in,
	// contact level, high = closed
	output logic contact_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		contact_out = 1'b0;
	end

	// close, hold for a number of cycles, then open again
	task automatic actuate(input int hold_cyc);
		@(posedge clk_sys_in);
		contact_out <= 1'b1;
		repeat (hold_cyc) @(posedge clk_sys_in);
		contact_out <= 1'b0;
	endtask
endmodule

// ---- verification/push_button_value_transmitter_test.sv ----
`define PBV_CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module push_button_value_transmitter_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CPM = 4;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [7:0] wb_adr_in = 8'h00;
	logic [3:0] wb_sel_in = 4'h0;
	logic [31:0] wb_dat_in = 32'h0;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic contact;
	logic tx_ready_in = 1'b0;
	logic tx_valid_out;
	pbv_pkg::pbv_tel_t tx_tel_out;
	pbv_pkg::pbv_tel_t tq[$];
	logic [31:0] rq[$];
	logic [31:0] mq[$];
	int fails = 0;
	int n_checks = 0;
	logic [7:0] rv;
	logic [7:0] fv;
	logic [31:0] exp_r;
	logic [31:0] exp_m;
	pbv_pkg::pbv_tel_t exp_t;

	always #4 clk_sys_in = ~clk_sys_in;

	pbv_value_tx #(.CYC_PER_MS(CPM)) DUT (
		.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.contact_in(contact),
		.tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out), .tx_tel_out(tx_tel_out)
	);

	pbv_contact_model PART (
		.clk_sys_in(clk_sys_in),
		.contact_out(contact)
	);

	// transmitter stalls at random, telegrams are held meanwhile
	always @(posedge clk_sys_in) begin
		tx_ready_in <= ($urandom % 4) != 0;
	end

	// one classic wishbone cycle; reads note their expectation first
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [31:0] mask);
		if (!we) begin
			rq.push_back(dat);
			mq.push_back(mask);
		end
		@(posedge clk_sys_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= adr;
		wb_sel_in <= 4'hF;
		wb_dat_in <= we ? dat : 32'h0;
		do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1);
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_cycle(1'b1, adr, dat, 32'h0);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
		wb_cycle(1'b0, adr, exp, mask);
	endtask

	task automatic expect_tel(input logic [2:0] f, input logic [7:0] v);
		pbv_pkg::pbv_tel_t t;
		t.func = f;
		t.value = v;
		tq.push_back(t);
	endtask

	// watcher: every result that appears is matched against the oldest note
	always @(posedge clk_sys_in) begin
		// notes are popped once, before the compare, so a failing print cannot eat a second note
		if (wb_ack_out === 1'b1 && wb_we_in === 1'b0 && rq.size() > 0) begin
			exp_r = rq.pop_front();
			exp_m = mq.pop_front();
			`PBV_CHK(wb_dat_out & exp_m, exp_r)
		end
		if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
			if (tq.size() == 0) begin
				fails++;
				$display("CHECK FAILED t=%0t unexpected telegram %h", $time, tx_tel_out);
			end else begin
				exp_t = tq.pop_front();
				`PBV_CHK(tx_tel_out, exp_t)
			end
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog sized well above the longest sequence
	initial begin
		#600us;
		fails++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h4F7E));
		repeat (12) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		// reset values, unmapped place reads zero
		rd(8'h00, 32'h2000, 32'hFFFFFFFF);
		rd(8'h04, 32'h64, 32'hFFFFFFFF);
		rd(8'h08, 32'h00, 32'hFFFFFFFF);
		rd(8'h0C, 32'h03, 32'hFFFFFFFF);
		rd(8'h10, 32'h0A, 32'hFFFFFFFF);
		rd(8'h3C, 32'h00, 32'hFFFFFFFF);
		// out-of-range limits are clamped
		wr(8'h0C, 32'h01);
		rd(8'h0C, 32'h03, 32'hFFFFFFFF);
		wr(8'h10, 32'h00);
		rd(8'h10, 32'h01, 32'hFFFFFFFF);
		wr(8'h10, 32'h0F);
		rd(8'h10, 32'h0A, 32'hFFFFFFFF);
		// every function on both edges
		for (int f = 0; f < 5; f++) begin
			rv = 8'($urandom);
			fv = 8'($urandom);
			wr(8'h00, 32'h20 | f);
			wr(8'h04, {24'h0, rv});
			wr(8'h08, {24'h0, fv});
			expect_tel(3'(f), (f == 1 || f == 2) ? (rv & 8'h3F) : rv);
			expect_tel(3'(f), (f == 1 || f == 2) ? (fv & 8'h3F) : fv);
			PART.actuate(20);
			repeat (20) @(posedge clk_sys_in);
		end
		// rising only: release is silent
		wr(8'h00, 32'h00);
		wr(8'h04, 32'h5A);
		expect_tel(3'h0, 8'h5A);
		PART.actuate(20);
		repeat (20) @(posedge clk_sys_in);
		// falling only: press is silent
		wr(8'h00, 32'h10);
		wr(8'h08, 32'hC3);
		expect_tel(3'h0, 8'hC3);
		PART.actuate(20);
		repeat (20) @(posedge clk_sys_in);
		// adjustment, 130 ms base times 3: one step in a 600 ms hold
		wr(8'h00, 32'h100);
		wr(8'h0C, 32'h03);
		wr(8'h04, 32'hFA);
		expect_tel(3'h0, 8'hFA);
		expect_tel(3'h0, 8'hFF);
		PART.actuate(600 * CPM);
		repeat (20) @(posedge clk_sys_in);
		expect_tel(3'h0, 8'hFF);
		expect_tel(3'h0, 8'hF5);
		PART.actuate(600 * CPM);
		repeat (20) @(posedge clk_sys_in);
		rd(8'h14, 32'hF5, 32'hFF);
		// 260 ms base times 6: steps at 1560, 3120, 4680 ms; the one due at 6240 ms is past 5 s
		wr(8'h00, 32'h1100);
		wr(8'h0C, 32'h06);
		wr(8'h04, 32'h10);
		expect_tel(3'h0, 8'h10);
		expect_tel(3'h0, 8'h1A);
		expect_tel(3'h0, 8'h24);
		expect_tel(3'h0, 8'h2E);
		PART.actuate(7000 * CPM);
		repeat (20) @(posedge clk_sys_in);
		// downward step saturates at 0, then clearing the enable ends the hold early
		wr(8'h00, 32'h2100);
		wr(8'h0C, 32'h03);
		wr(8'h04, 32'h05);
		expect_tel(3'h0, 8'h05);
		expect_tel(3'h0, 8'h00);
		fork
			PART.actuate(2400 * CPM);
			begin
				repeat (1800 * CPM) @(posedge clk_sys_in);
				wr(8'h00, 32'h2000);
			end
		join
		repeat (20) @(posedge clk_sys_in);
		rd(8'h14, 32'h200, 32'hFFF);
		// both edges: long hold never steps
		wr(8'h00, 32'h120);
		wr(8'h04, 32'h07);
		wr(8'h08, 32'h09);
		expect_tel(3'h0, 8'h07);
		expect_tel(3'h0, 8'h09);
		PART.actuate(600 * CPM);
		repeat (40) @(posedge clk_sys_in);
		`PBV_CHK(tq.size(), 0)
		end_of_test();
	end
endmodule
